/* frame_composer.sv */
// Overview of operation
// - Control bits 31 to 16 always read as zero.
// - Control bits 15, 9 and 7 to 4 always read as zero.
// - Bit 14 appends the 4-bit chip identifier to the frame.
// - Bits 13-12 pick supply high, low or both flags for the frame.
// - Bits 11-10 pick input high, low or both flags for the frame.
// - Bit 8 appends the 4-bit input range code.
// - Bit 3 appends result parity then frame parity at the end.
// - Result parity is even parity of the 14 result bits only.
// - Frame parity is even over all bits except the result parity.
// - Parity makes the frame two bits longer; the host clocks them.
// - Bits 2-0 choose result, zeros, ones or alternating patterns.
//
// Decided for this implementation: the register addresses and the plain strobed port.
module frame_composer (
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  input  wire logic        i_ce,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic [13:0] i_conv_data,
  input  wire logic        i_conv_valid,
  input  wire logic        i_supply_high,
  input  wire logic        i_supply_low,
  input  wire logic        i_input_high,
  input  wire logic        i_input_low,
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  output logic             o_serial_out_lane0,
  output logic             o_serial_out_lane0_oe,
  output logic             o_frame_busy
);
  // ****************************************
  // Registers and state
  // ****************************************
  logic [31:0] output_frame_control;
  logic [3:0]  include_chip_id_val;
  logic [3:0]  range_code;
  logic [13:0] result;
  logic        dirty;
  logic        cs_meta;
  logic        cs_sync;
  logic        hold_load;
  logic [27:0] hold_frame;
  logic [4:0]  hold_len;
  logic [27:0] next_frame;
  logic [4:0]  next_len;
  logic        busy;

  frame_link_if lk ();

  // ****************************************
  // Field decode
  // ****************************************
  logic       include_chip_id;
  logic [1:0] include_supply_alarm;
  logic [1:0] include_input_alarm;
  logic       include_range_code;
  logic       parity_enable;
  logic [2:0] output_value_select;

  assign include_chip_id      = output_frame_control[frame_pkg::CHIP_BIT];
  assign include_supply_alarm = output_frame_control[frame_pkg::SUP_LSB +: 2];
  assign include_input_alarm  = output_frame_control[frame_pkg::INP_LSB +: 2];
  assign include_range_code   = output_frame_control[frame_pkg::RANGE_BIT];
  assign parity_enable        = output_frame_control[frame_pkg::PAR_BIT];
  assign output_value_select  = output_frame_control[frame_pkg::VAL_LSB +: 3];

  // Pick the value that stands in the result slot
  function automatic logic [13:0] pick_value(input logic [2:0] sel,
                                             input logic [13:0] conv);
    logic [13:0] v;
    v = conv;
    if (sel[2]) begin
      unique case (frame_pkg::value_sel_t'(sel))
        frame_pkg::VAL_ZERO: v = frame_pkg::PAT_ZERO;
        frame_pkg::VAL_ONE:  v = frame_pkg::PAT_ONE;
        frame_pkg::VAL_ALT1: v = frame_pkg::PAT_ALT1;
        frame_pkg::VAL_ALT2: v = frame_pkg::PAT_ALT2;
      endcase
    end
    return v;
  endfunction

  // Append a two-flag field, high flag first when both are chosen
  function automatic logic [29:0] add_flags(input logic [27:0] acc,
                                            input logic [4:0] n,
                                            input logic [1:0] sel,
                                            input logic hi,
                                            input logic lo);
    logic [27:0] a;
    logic [4:0]  m;
    a = acc;
    m = n;
    unique case (sel)
      2'b01: begin
        a = {a[26:0], hi};
        m = m + 5'd1;
      end
      2'b10: begin
        a = {a[26:0], lo};
        m = m + 5'd1;
      end
      2'b11: begin
        a = {a[25:0], hi, lo};
        m = m + 5'd2;
      end
      2'b00: begin
        a = acc;
      end
    endcase
    return {a[24:0], m};
  endfunction

  // ****************************************
  // Frame composition
  // ****************************************
  // Built right-justified, then moved to the top so bit 27 leaves first
  always_comb begin
    logic [27:0] acc;
    logic [4:0]  n;
    logic [29:0] r;
    logic [13:0] val;
    logic        cpar;
    logic        fpar;
    acc  = 28'h0;
    n    = 5'd14;
    r    = 30'h0;
    val  = 14'h0;
    cpar = 1'b0;
    fpar = 1'b0;
    val = pick_value(output_value_select, result);
    acc = {14'h0, val};
    if (include_chip_id) begin
      acc = {acc[23:0], include_chip_id_val};
      n   = n + 5'd4;
    end
    r   = add_flags(acc, n, include_supply_alarm, i_supply_high, i_supply_low);
    acc = {3'h0, r[29:5]};
    n   = r[4:0];
    r   = add_flags(acc, n, include_input_alarm, i_input_high, i_input_low);
    acc = {3'h0, r[29:5]};
    n   = r[4:0];
    if (include_range_code) begin
      acc = {acc[23:0], range_code};
      n   = n + 5'd4;
    end
    cpar = ^val;
    fpar = ^acc;
    if (parity_enable) begin
      acc = {acc[25:0], cpar, fpar};
      n   = n + 5'd2;
    end
    next_frame = acc << (5'd28 - n);
    next_len   = n;
  end

  // ****************************************
  // Register bus slave
  // ****************************************
  // Only documented writable bits are stored
  // upper half zero
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      output_frame_control <= frame_pkg::CTRL_RESET;
    end else if (i_ce && i_wr && i_addr == frame_pkg::CTRL_ADDR) begin
      output_frame_control <= i_wdata & frame_pkg::CTRL_WMASK;
    end
  end

  // Chip identifier and range code feed the appended fields
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      include_chip_id_val <= frame_pkg::CHIP_RESET;
      range_code          <= frame_pkg::RANGE_RESET;
    end else if (i_ce && i_wr) begin
      if (i_addr == frame_pkg::CHIP_ADDR) begin
        include_chip_id_val <= i_wdata[3:0];
      end
      if (i_addr == frame_pkg::RANGE_ADDR) begin
        range_code <= i_wdata[3:0];
      end
    end
  end

  // Read data stand in the cycle after the strobe only
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 32'h0;
    end else if (i_ce) begin
      o_rdata <= 32'h0;
      if (i_rd) begin
        unique case (i_addr)
          frame_pkg::CTRL_ADDR:   o_rdata <= output_frame_control;
          frame_pkg::CHIP_ADDR:   o_rdata <= {28'h0, include_chip_id_val};
          frame_pkg::RANGE_ADDR:  o_rdata <= {28'h0, range_code};
          frame_pkg::STATUS_ADDR: o_rdata <= {24'h0, hold_len, busy, dirty, 1'b0};
          default:                o_rdata <= 32'h0;
        endcase
      end
    end
  end

  // ****************************************
  // Chip select crossing and snapshot
  // ****************************************
  // Two stages; only the second is looked at
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
    end else if (i_ce) begin
      cs_meta <= i_cs_n;
      cs_sync <= cs_meta;
    end
  end

  assign busy         = ~cs_sync;
  assign o_frame_busy = busy;
  assign hold_load    = i_ce & dirty & ~busy;

  // Latest conversion result
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      result <= 14'h0;
    end else if (i_ce && i_conv_valid) begin
      result <= i_conv_data;
    end
  end

  // New data or settings mark the snapshot stale; a new event wins over the load
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      dirty <= 1'b1;
    end else if (i_ce) begin
      if (i_conv_valid || i_wr) begin
        dirty <= 1'b1;
      end else if (hold_load) begin
        dirty <= 1'b0;
      end
    end
  end

  // Snapshot is frozen while a frame runs, so the link side reads it safely
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      hold_frame <= 28'h0;
      hold_len   <= 5'd14;
    end else if (hold_load) begin
      hold_frame <= next_frame;
      hold_len   <= next_len;
    end
  end

  assign lk.frame = hold_frame;
  assign lk.len   = hold_len;

  frame_shifter u_shift (
    .i_sclk   (i_sclk),
    .i_nrst   (i_nrst),
    .i_cs_n   (i_cs_n),
    .lk       (lk.link),
    .o_sdo    (o_serial_out_lane0),
    .o_sdo_oe (o_serial_out_lane0_oe)
  );

  // ****************************************
  // Checks
  // ****************************************
  a_ctrl_upper_zero: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    $past(i_rd && i_ce && i_addr == frame_pkg::CTRL_ADDR) |-> o_rdata[31:16] == 16'h0)
    else $error("control upper half not zero");

  a_ctrl_resv_zero: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    $past(i_rd && i_ce && i_addr == frame_pkg::CTRL_ADDR)
      |-> (o_rdata[15] | o_rdata[9] | (|o_rdata[7:4])) == 1'b0)
    else $error("control reserved bits not zero");

  a_chip_id_slot: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    hold_load && include_chip_id |=> hold_frame[13:10] == $past(include_chip_id_val))
    else $error("chip id not after result");

  a_supply_both: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    hold_load && include_chip_id && include_supply_alarm == 2'b11
      |=> hold_frame[9:8] == {$past(i_supply_high), $past(i_supply_low)})
    else $error("supply flags misplaced");

  a_input_low_only: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    hold_load && !include_chip_id && include_supply_alarm == 2'b00 && include_input_alarm == 2'b10
      |=> hold_frame[13] == $past(i_input_low) && hold_len == 5'd15)
    else $error("input low flag misplaced");

  a_range_slot: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    hold_load && output_frame_control[14:9] == 6'h0 && include_range_code
      |=> hold_frame[13:10] == $past(range_code))
    else $error("range code misplaced");

  a_parity_len: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    hold_load && output_frame_control[14:8] == 7'h0 && parity_enable |=> hold_len == 5'd16)
    else $error("parity frame length wrong");

  a_result_parity: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    hold_load && output_frame_control[14:8] == 7'h0 && parity_enable
      |=> hold_frame[13] == ^hold_frame[27:14])
    else $error("result parity wrong");

  a_frame_parity: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    hold_load && output_frame_control[14:8] == 7'h40 && parity_enable
      |=> hold_frame[8] == ^hold_frame[27:10])
    else $error("frame parity wrong");

  a_all_ones: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    hold_load && output_value_select == 3'b101 |=> hold_frame[27:14] == 14'h3fff)
    else $error("all ones pattern wrong");

  a_frozen_frame: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    busy && $past(busy) |-> $stable(hold_frame) && $stable(hold_len))
    else $error("snapshot changed during frame");
endmodule

/* frame_pkg.sv */
package frame_pkg;
  // ****************************************
  // Register map, byte addresses
  // ****************************************
  localparam logic [7:0] CTRL_ADDR   = 8'h10;
  localparam logic [7:0] CHIP_ADDR   = 8'h04;
  localparam logic [7:0] RANGE_ADDR  = 8'h14;
  localparam logic [7:0] STATUS_ADDR = 8'h20;

  // ****************************************
  // Control register layout
  // ****************************************
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_7d0f;
  localparam int CHIP_BIT  = 14;
  localparam int SUP_LSB   = 12;
  localparam int INP_LSB   = 10;
  localparam int RANGE_BIT = 8;
  localparam int PAR_BIT   = 3;
  localparam int VAL_LSB   = 0;

  // ****************************************
  // Frame geometry and test values
  // ****************************************
  localparam int RESULT_W  = 14;
  localparam int FRAME_MAX = 28;
  localparam int LEN_W     = 5;
  localparam logic [13:0] PAT_ZERO = 14'h0000;
  localparam logic [13:0] PAT_ONE  = 14'h3fff;
  localparam logic [13:0] PAT_ALT1 = 14'h1555;
  localparam logic [13:0] PAT_ALT2 = 14'h0ccc;
  localparam logic [3:0]  CHIP_RESET  = 4'h0;
  localparam logic [3:0]  RANGE_RESET = 4'h0;

  // Output value selections
  typedef enum logic [2:0] {
    VAL_ZERO = 3'b100,
    VAL_ONE  = 3'b101,
    VAL_ALT1 = 3'b110,
    VAL_ALT2 = 3'b111
  } value_sel_t;
endpackage

/* frame_link_if.sv */
// Snapshot of one frame, held still while the host clocks it out
interface frame_link_if;
  logic [27:0] frame;
  logic [4:0]  len;
  modport sys  (output frame, output len);
  modport link (input frame, input len);
endinterface

/* frame_shifter.sv */
// ****************************************
// Link-side serializer on the serial clock
// ****************************************
module frame_shifter (
  input  wire logic  i_sclk,
  input  wire logic  i_nrst,
  input  wire logic  i_cs_n,
  frame_link_if.link lk,
  output logic       o_sdo,
  output logic       o_sdo_oe
);
  logic [4:0] bit_cnt;
  logic       frame_rst_n;

  // Chip select ends the frame itself, since the clock stops between frames
  assign frame_rst_n = i_nrst & ~i_cs_n;

  // Advance on falling edge so the host samples on the rising edge
  always_ff @(negedge i_sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt <= 5'h00;
    end else if (bit_cnt != 5'h1f) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  // Bits past the frame length read as zero
  // longer frame
  always_comb begin
    o_sdo = 1'b0;
    if (bit_cnt < lk.len) begin
      o_sdo = lk.frame[5'd27 - bit_cnt];
    end
  end

  assign o_sdo_oe = ~i_cs_n;
endmodule

/* spi_host_model.sv */
// ****************************************
// Host side of the serial frame link
// ****************************************
module spi_host_model;
  timeunit 1ns;
  timeprecision 1ps;

  logic sclk = 1'b0;
  logic cs_n = 1'b1;
  logic sdo;

  // Mode 0: sample on rise, clock parked low between frames
  // longest frame clocked
  task automatic read_frame(output logic [27:0] f);
    f = '0;
    // Off the system edge so the select never races the synchroniser
    #5 cs_n = 1'b0;
    // Device needs two system cycles to freeze its snapshot
    #300;
    for (int i = 27; i >= 0; i--) begin
      #24 sclk = 1'b1;
      f[i] = sdo;
      #24 sclk = 1'b0;
    end
    #30 cs_n = 1'b1;
  endtask
endmodule

/* adc_output_frame_composer_tb.sv */
module adc_output_frame_composer_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        i_clk_sys    = 1'b0;
  logic        i_nrst       = 1'b0;
  logic        i_ce         = 1'b1;
  logic [7:0]  i_addr       = 8'h00;
  logic [31:0] i_wdata      = 32'h0000_0000;
  logic        i_wr         = 1'b0;
  logic        i_rd         = 1'b0;
  logic [31:0] o_rdata;
  logic [13:0] i_conv_data  = 14'h0000;
  logic        i_conv_valid = 1'b0;
  logic        sup_hi       = 1'b1;
  logic        sup_lo       = 1'b0;
  logic        in_hi        = 1'b0;
  logic        in_lo        = 1'b1;
  logic        sdo_oe;
  logic        busy;
  logic [3:0]  chip_id      = 4'ha;
  logic [3:0]  range_code   = 4'h5;
  logic [27:0] got_frame;
  logic [31:0] ctrl_tab [10] = '{32'h0000_0000, 32'h0000_5908, 32'h0000_2408, 32'h0000_3c0c,
                                 32'h0000_7d0d, 32'h0000_000e, 32'h0000_410f, 32'h0000_0803,
                                 32'h0000_4008, 32'h0000_0103};
  int          err_count   = 0;
  int          check_count = 0;

  spi_host_model host ();

  frame_composer DUT (
    .i_clk_sys             (i_clk_sys),
    .i_nrst                (i_nrst),
    .i_ce                  (i_ce),
    .i_addr                (i_addr),
    .i_wdata               (i_wdata),
    .i_wr                  (i_wr),
    .i_rd                  (i_rd),
    .o_rdata               (o_rdata),
    .i_conv_data           (i_conv_data),
    .i_conv_valid          (i_conv_valid),
    .i_supply_high         (sup_hi),
    .i_supply_low          (sup_lo),
    .i_input_high          (in_hi),
    .i_input_low           (in_lo),
    .i_sclk                (host.sclk),
    .i_cs_n                (host.cs_n),
    .o_serial_out_lane0    (host.sdo),
    .o_serial_out_lane0_oe (sdo_oe),
    .o_frame_busy          (busy)
  );

  // ****************************************
  // Clock and watchdog
  // ****************************************
  initial begin
    forever #25 i_clk_sys = ~i_clk_sys;
  end

  // Whole run is well under 40 us; a hang is cut off far beyond that
  initial begin
    #200000;
    err_count++;
    print_verdict();
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    @(posedge i_clk_sys);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd   <= 1'b0;
    @(negedge i_clk_sys);
    check(name, exp, o_rdata);
  endtask

  // Expected frame, MSB first, left aligned, zero past its length
  function automatic logic [27:0] exp_frame(input logic [31:0] c);
    logic        q[$];
    logic [13:0] v;
    logic [27:0] f;
    logic        fp;
    case (c[2:0])
      3'b100:  v = 14'h0000;
      3'b101:  v = 14'h3fff;
      3'b110:  v = frame_pkg::PAT_ALT1;
      3'b111:  v = frame_pkg::PAT_ALT2;
      default: v = i_conv_data;
    endcase
    for (int i = 13; i >= 0; i--) q.push_back(v[i]);
    if (c[14]) for (int i = 3; i >= 0; i--) q.push_back(chip_id[i]);
    if (c[12]) q.push_back(sup_hi);
    if (c[13]) q.push_back(sup_lo);
    if (c[10]) q.push_back(in_hi);
    if (c[11]) q.push_back(in_lo);
    if (c[8]) for (int i = 3; i >= 0; i--) q.push_back(range_code[i]);
    fp = 1'b0;
    foreach (q[i]) fp ^= q[i];
    if (c[3]) begin
      q.push_back(^v);
      q.push_back(fp);
    end
    f = '0;
    foreach (q[i]) f[27-i] = q[i];
    return f;
  endfunction

  task automatic print_verdict();
    $display("Checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    bus_wr(frame_pkg::CTRL_ADDR, 32'hffff_ffff);
    bus_rd(frame_pkg::CTRL_ADDR, 32'h0000_7d0f, "ctrl_reserved");
    bus_wr(frame_pkg::CTRL_ADDR, 32'h0000_0000);
    bus_rd(frame_pkg::CTRL_ADDR, 32'h0000_0000, "ctrl_clear");
    // A write while the clock enable is low must be ignored
    @(posedge i_clk_sys);
    i_ce <= 1'b0;
    bus_wr(frame_pkg::CTRL_ADDR, 32'h0000_7d0f);
    @(posedge i_clk_sys);
    i_ce <= 1'b1;
    bus_rd(frame_pkg::CTRL_ADDR, 32'h0000_0000, "ctrl_frozen");
    bus_rd(8'h30, 32'h0000_0000, "unmapped");
    bus_wr(frame_pkg::CHIP_ADDR, {28'h0, chip_id});
    bus_wr(frame_pkg::RANGE_ADDR, {28'h0, range_code});
    // Each control setting is framed once with fresh data
    for (int k = 0; k < 10; k++) begin
      bus_wr(frame_pkg::CTRL_ADDR, ctrl_tab[k]);
      @(posedge i_clk_sys);
      i_conv_data  <= 14'h2a5c ^ 14'(k * 14'h0111);
      i_conv_valid <= 1'b1;
      @(posedge i_clk_sys);
      i_conv_valid <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
      // Busy flag and pin enable looked at while the frame runs
      fork
        host.read_frame(got_frame);
        begin
          repeat (8) @(negedge i_clk_sys);
          check("busy_frame", 32'h1, {31'h0, busy});
          check("oe_frame", 32'h1, {31'h0, sdo_oe});
        end
      join
      check($sformatf("frame_%0d", k), {4'h0, exp_frame(ctrl_tab[k])}, {4'h0, got_frame});
      repeat (5) @(posedge i_clk_sys);
      check("oe_idle", 32'h0, {31'h0, sdo_oe});
      check("busy_idle", 32'h0, {31'h0, busy});
    end
    print_verdict();
  end
endmodule
